// >>> pkg/ocrfc_regs.vh
// Register offsets, field positions, reset values and timing constants
// for the overcurrent retry and foldback controller.
// Assumes inclusion by bare name from the design files.
`ifndef OCRFC_REGS_VH
`define OCRFC_REGS_VH

`define OCRFC_ADDR_FAULT_PRESENT   8'h03
`define OCRFC_ADDR_FAULT_LATCH     8'h04
`define OCRFC_ADDR_RETRY_CONTROL   8'h0B
`define OCRFC_ADDR_LIMIT_FOLD_CFG  8'h0D
`define OCRFC_ADDR_DELAY_CFG       8'h0E
`define OCRFC_ADDR_REBOOT_STATUS   8'hA2
`define OCRFC_ADDR_NV_LIMIT_FOLD   8'hAD

// Field positions.
`define OCRFC_BIT_OC_PRESENT       1
`define OCRFC_BIT_OVERCURRENT_FAULT_LATCH         1
`define OCRFC_BIT_DELAY_RUNNING    0
`define OCRFC_OVERCURRENT_RETRY_COUNT_SEL_LSB         0
`define OCRFC_LIM_SEL_LSB          0
`define OCRFC_FOLD_SEL_LSB         4
`define OCRFC_BIT_LOAD_POWER_FOLD_EN             6
`define OCRFC_BIT_NORMAL_FOLD_DISABLE           7
`define OCRFC_COOL_SEL_LSB         0

// Retry field encodings.
`define OCRFC_RETRY_NONE           2'h0
`define OCRFC_RETRY_ONE            2'h1
`define OCRFC_RETRY_SEVEN          2'h2
`define OCRFC_RETRY_LIMIT_ONE      3'h1
`define OCRFC_RETRY_LIMIT_SEVEN    3'h7

// Reset values.
`define OCRFC_RST_RETRY_CONTROL    8'h00
`define OCRFC_RST_DELAY_CFG        8'h00
`define OCRFC_RST_NV_LIMIT_FOLD    8'h0F

// Current limit: 15 mV base, 1 mV step, top code 15 gives 30 mV.
`define OCRFC_LIM_BASE_MV          6'h0F

// Foldback ratios in percent.
`define OCRFC_FOLD_PCT_10          7'h0A
`define OCRFC_FOLD_PCT_20          7'h14
`define OCRFC_FOLD_PCT_50          7'h32
`define OCRFC_FOLD_PCT_100         7'h64

// Attenuated output voltage knees, in millivolts.
`define OCRFC_KNEE_MV              11'h384
`define OCRFC_TOP_MV               11'h708

// Timing: the clock in Hz, times in milliseconds.
`define OCRFC_CLK_HZ               25000000
`define OCRFC_COOL_BASE_MS         512
`define OCRFC_RETRY_RESET_MS       16400

`endif

// >>> core/ocrfc_fold_calc.v
// Combinational current-limit and foldback calculator.
// Assumes inputs are stable register fields and a synchronised
// attenuated output voltage sample in millivolts.
`timescale 1ns/1ps
`default_nettype none
`include "ocrfc_regs.vh"

module ocrfc_fold_calc (
  input  wire [3:0]  lim_sel,
  input  wire [1:0]  fold_ratio_sel,
  input  wire        load_power_fold_en,
  input  wire        normal_fold_disable,
  input  wire        normal_mode,
  input  wire [10:0] out_mv,
  output wire [5:0]  sense_limit_voltage,
  output wire [6:0]  fast_pulldown_threshold,
  output reg  [6:0]  fold_pct
);

  reg [6:0]  base_pct;
  reg [17:0] ramp;
  reg [17:0] quot;

  assign sense_limit_voltage     = `OCRFC_LIM_BASE_MV + {2'h0, lim_sel};
  assign fast_pulldown_threshold = {sense_limit_voltage, 1'b0};

  always @* begin
    case (fold_ratio_sel)
      2'h0:    base_pct = `OCRFC_FOLD_PCT_10;
      2'h1:    base_pct = `OCRFC_FOLD_PCT_20;
      2'h2:    base_pct = `OCRFC_FOLD_PCT_50;
      default: base_pct = `OCRFC_FOLD_PCT_100;
    endcase
    ramp     = 18'h0;
    quot     = 18'h0;
    fold_pct = base_pct;
    if (!normal_mode) begin
      fold_pct = base_pct;
    end else if (out_mv < `OCRFC_KNEE_MV) begin
      if (normal_fold_disable) begin
        fold_pct = `OCRFC_FOLD_PCT_100;
      end else begin
        ramp     = {11'h0, `OCRFC_FOLD_PCT_100 - base_pct} * {7'h0, out_mv};
        quot     = ramp / {7'h0, `OCRFC_KNEE_MV};
        fold_pct = base_pct + quot[6:0];
      end
    end else if (load_power_fold_en) begin
      // Applies regardless of the disable bit.
      if (out_mv >= `OCRFC_TOP_MV) begin
        fold_pct = `OCRFC_FOLD_PCT_50;
      end else begin
        // The slope drops half of full limit over one knee width.
        ramp     = {7'h0, out_mv - `OCRFC_KNEE_MV} * {11'h0, `OCRFC_FOLD_PCT_50};
        quot     = ramp / {7'h0, `OCRFC_KNEE_MV};
        fold_pct = `OCRFC_FOLD_PCT_100 - quot[6:0];
      end
    end else begin
      fold_pct = `OCRFC_FOLD_PCT_100;
    end
  end

endmodule
`default_nettype wire

// >>> core/ocrfc_ctrl.v
// Overcurrent fault, cooling delay, retry and foldback control.
// Assumes analog comparator levels arrive asynchronously and a simple
// byte register port (address, write strobe, write data, read data).
// Function
// - Hold overcurrent-present while limiting and timer charging.
// - Timer threshold latches fault and pulls gates low.
// - Clear overcurrent-present once gates are off.
// - Nonzero retry field allows turn-on after cooling.
// - Cooling delay 512 ms to 65.5 s, binary steps.
// - Delay-running bit set throughout cooling delay.
// - Retry field selects none, one, seven, unlimited.
// - Finite retries start 16.4 s counter reset timer.
// - Fault before expiry increments count, else clears.
// - Retries exhausted plus new fault latches off.
// - Reset timer disabled before power good.
// - Own retry counter and timer, not shared.
// - Retry none: off until latch reset, then delay.
// - Sense limit 15 to 30 mV, 1 mV steps.
// - Limit config defaults from nonvolatile copy.
// - Fast pull-down threshold is twice sense limit.
// - Foldback field picks 10, 20, 50, 100 percent.
// - Startup foldback is flat at folded level.
// - Normal foldback ramps to 100 percent at 0.9 V.
// - Load-power foldback falls to 50 percent at 1.8 V.
// - Fold disable acts only in normal operation.
// - Load-power foldback ignores fold disable.
`timescale 1ns/1ps
`default_nettype none
`include "ocrfc_regs.vh"

module ocrfc_ctrl #(
  parameter integer COOL_BASE_CYC   = `OCRFC_CLK_HZ / 1000 * `OCRFC_COOL_BASE_MS,
  parameter integer RETRY_RESET_CYC = `OCRFC_CLK_HZ / 1000 * `OCRFC_RETRY_RESET_MS
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  input  wire        gate_on_req,
  input  wire        limit_engaged_in,
  input  wire        timer_charging_in,
  input  wire        timer_threshold_in,
  input  wire        power_good_in,
  input  wire [10:0] out_mv_in,
  output wire        gate_enable,
  output wire [5:0]  sense_limit_voltage,
  output wire [6:0]  fast_pulldown_threshold,
  output reg  [6:0]  fold_pct_q
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  reg [3:0]  sync1_q;
  reg [3:0]  sync2_q;
  reg [10:0] mv1_q;
  reg [10:0] mv2_q;
  wire limit_s  = sync2_q[0];
  wire charge_s = sync2_q[1];
  wire thresh_s = sync2_q[2];
  wire pgood_s  = sync2_q[3];

  // The voltage word is assumed slow; a transient multi-bit skew only
  // perturbs the foldback ratio for one cycle.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      mv1_q   <= 11'h000;
      mv2_q   <= 11'h000;
    end else begin
      sync1_q <= {power_good_in, timer_threshold_in, timer_charging_in, limit_engaged_in};
      sync2_q <= sync1_q;
      mv1_q   <= out_mv_in;
      mv2_q   <= mv1_q;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  reg [7:0] retry_ctl_q;
  reg [7:0] limit_cfg_q;
  reg [7:0] delay_cfg_q;
  reg [7:0] nv_default_q;
  reg       oc_present_q;
  reg       overcurrent_fault_latch_q;
  reg       delay_run_q;
  reg       cfg_loaded_q;
  reg       gate_on_q;

  wire [1:0] retry_sel = retry_ctl_q[`OCRFC_OVERCURRENT_RETRY_COUNT_SEL_LSB +: 2];
  // Eight codes span 512 ms to 65.5 s; a wider code would overflow the count.
  wire [2:0] cool_sel  = delay_cfg_q[`OCRFC_COOL_SEL_LSB +: 3];
  wire       fault_set = thresh_s && gate_on_q;
  wire       wr_fault  = reg_wr && (reg_addr == `OCRFC_ADDR_FAULT_LATCH);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      retry_ctl_q  <= `OCRFC_RST_RETRY_CONTROL;
      delay_cfg_q  <= `OCRFC_RST_DELAY_CFG;
      nv_default_q <= `OCRFC_RST_NV_LIMIT_FOLD;
      limit_cfg_q  <= `OCRFC_RST_NV_LIMIT_FOLD;
      cfg_loaded_q <= 1'b0;
    end else begin
      if (!cfg_loaded_q) begin
        limit_cfg_q  <= nv_default_q;
        cfg_loaded_q <= 1'b1;
      end else if (reg_wr && reg_addr == `OCRFC_ADDR_LIMIT_FOLD_CFG) begin
        limit_cfg_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `OCRFC_ADDR_RETRY_CONTROL) begin
        retry_ctl_q <= reg_wdata;
      end else if (reg_wr && reg_addr == `OCRFC_ADDR_DELAY_CFG) begin
        delay_cfg_q <= reg_wdata;
      end else if (reg_wr && reg_addr == `OCRFC_ADDR_NV_LIMIT_FOLD) begin
        nv_default_q <= reg_wdata;
      end
    end
  end

  always @* begin
    reg_rdata = 8'h00;
    if (reg_addr == `OCRFC_ADDR_FAULT_PRESENT) begin
      reg_rdata[`OCRFC_BIT_OC_PRESENT] = oc_present_q;
    end else if (reg_addr == `OCRFC_ADDR_FAULT_LATCH) begin
      reg_rdata[`OCRFC_BIT_OVERCURRENT_FAULT_LATCH] = overcurrent_fault_latch_q;
    end else if (reg_addr == `OCRFC_ADDR_RETRY_CONTROL) begin
      reg_rdata = retry_ctl_q;
    end else if (reg_addr == `OCRFC_ADDR_LIMIT_FOLD_CFG) begin
      reg_rdata = limit_cfg_q;
    end else if (reg_addr == `OCRFC_ADDR_DELAY_CFG) begin
      reg_rdata = delay_cfg_q;
    end else if (reg_addr == `OCRFC_ADDR_REBOOT_STATUS) begin
      reg_rdata[`OCRFC_BIT_DELAY_RUNNING] = delay_run_q;
    end else if (reg_addr == `OCRFC_ADDR_NV_LIMIT_FOLD) begin
      reg_rdata = nv_default_q;
    end
  end

  // ==========================================================================
  // Fault state machine
  // ==========================================================================
  localparam [1:0] ST_OFF  = 2'h0;
  localparam [1:0] ST_ON   = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;
  localparam [1:0] ST_COOL = 2'h3;

  reg [1:0]  state_q;
  reg [31:0] cool_cnt_q;
  reg [31:0] rst_cnt_q;
  reg        rst_run_q;
  reg [2:0]  retry_cnt_q;

  wire [31:0] cool_len  = COOL_BASE_CYC << cool_sel;
  wire [2:0]  retry_max = (retry_sel == `OCRFC_RETRY_ONE) ? `OCRFC_RETRY_LIMIT_ONE
                                                          : `OCRFC_RETRY_LIMIT_SEVEN;
  wire        finite    = (retry_sel == `OCRFC_RETRY_ONE) || (retry_sel == `OCRFC_RETRY_SEVEN);
  // The count holds faults seen since the first retry, so it stands one short
  // of the limit when the last allowed retry has been used.
  wire        exhausted = finite && rst_run_q && (retry_cnt_q >= retry_max - 3'h1);
  wire        clr_fault = wr_fault && reg_wdata[`OCRFC_BIT_OVERCURRENT_FAULT_LATCH];

  assign gate_enable = gate_on_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= ST_OFF;
      gate_on_q    <= 1'b0;
      overcurrent_fault_latch_q   <= 1'b0;
      oc_present_q <= 1'b0;
      delay_run_q  <= 1'b0;
      cool_cnt_q   <= 32'h0;
      rst_cnt_q    <= 32'h0;
      rst_run_q    <= 1'b0;
      retry_cnt_q  <= 3'h0;
    end else begin
      oc_present_q <= gate_on_q && limit_s && charge_s && !fault_set;
      // Hardware set wins over a software clear in the same cycle.
      if (fault_set) begin
        overcurrent_fault_latch_q <= 1'b1;
      end else if (clr_fault) begin
        overcurrent_fault_latch_q <= 1'b0;
      end
      // Reset timer, separate from any other fault's timer.
      if (rst_run_q && pgood_s) begin
        if (rst_cnt_q >= RETRY_RESET_CYC - 1) begin
          rst_run_q   <= 1'b0;
          retry_cnt_q <= 3'h0;
        end else begin
          rst_cnt_q <= rst_cnt_q + 32'h1;
        end
      end
      case (state_q)
        ST_OFF: begin
          if (gate_on_req) begin
            gate_on_q <= 1'b1;
            state_q   <= ST_ON;
          end
        end
        ST_ON: begin
          if (fault_set) begin
            gate_on_q <= 1'b0;
            if (rst_run_q && finite) begin
              retry_cnt_q <= retry_cnt_q + 3'h1;
              rst_run_q   <= 1'b0;
            end
            if (retry_sel == `OCRFC_RETRY_NONE || exhausted) begin
              state_q <= ST_HOLD;
            end else begin
              state_q     <= ST_COOL;
              delay_run_q <= 1'b1;
              cool_cnt_q  <= 32'h0;
            end
          end else if (!gate_on_req) begin
            gate_on_q <= 1'b0;
            state_q   <= ST_OFF;
          end
        end
        ST_HOLD: begin
          if (!overcurrent_fault_latch_q) begin
            state_q     <= ST_COOL;
            delay_run_q <= 1'b1;
            cool_cnt_q  <= 32'h0;
          end
        end
        default: begin
          if (cool_cnt_q >= cool_len - 32'h1) begin
            delay_run_q <= 1'b0;
            if (gate_on_req) begin
              gate_on_q <= 1'b1;
              state_q   <= ST_ON;
              if (finite) begin
                rst_run_q <= 1'b1;
                rst_cnt_q <= 32'h0;
              end
            end else begin
              state_q <= ST_OFF;
            end
          end else begin
            cool_cnt_q <= cool_cnt_q + 32'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Current limit and foldback
  // ==========================================================================
  wire [6:0] fold_pct_d;

  ocrfc_fold_calc u_fold (
    .lim_sel                 (limit_cfg_q[`OCRFC_LIM_SEL_LSB +: 4]),
    .fold_ratio_sel          (limit_cfg_q[`OCRFC_FOLD_SEL_LSB +: 2]),
    .load_power_fold_en      (limit_cfg_q[`OCRFC_BIT_LOAD_POWER_FOLD_EN]),
    .normal_fold_disable     (limit_cfg_q[`OCRFC_BIT_NORMAL_FOLD_DISABLE]),
    .normal_mode             (pgood_s),
    .out_mv                  (mv2_q),
    .sense_limit_voltage     (sense_limit_voltage),
    .fast_pulldown_threshold (fast_pulldown_threshold),
    .fold_pct                (fold_pct_d)
  );

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fold_pct_q <= `OCRFC_FOLD_PCT_100;
    end else begin
      fold_pct_q <= fold_pct_d;
    end
  end

endmodule
`default_nettype wire

// >>> verification/ocrfc_ctrl_chk.sv
// Port-level checker for the overcurrent retry and foldback controller.
// Assumes one clock domain; bound to every instance of the controller.
`timescale 1ns/1ps
`default_nettype none
module ocrfc_ctrl_chk #(
  parameter integer COOL_BASE_CYC   = 20,
  parameter integer RETRY_RESET_CYC = 200
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        gate_on_req,
  input wire logic        limit_engaged_in,
  input wire logic        timer_charging_in,
  input wire logic        timer_threshold_in,
  input wire logic        power_good_in,
  input wire logic [10:0] out_mv_in,
  input wire logic        gate_enable,
  input wire logic [5:0]  sense_limit_voltage,
  input wire logic [6:0]  fast_pulldown_threshold,
  input wire logic [6:0]  fold_pct_q
);
  // ====================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_fast_twice_limit: assert property (fast_pulldown_threshold == {sense_limit_voltage, 1'b0})
    else $error("fast threshold not twice the limit");
  a_limit_in_span: assert property (sense_limit_voltage >= 6'h0F && sense_limit_voltage <= 6'h1E)
    else $error("sense limit outside span");
  a_trip_gates_off: assert property ($rose(timer_threshold_in) && gate_enable |-> ##[1:4] !gate_enable)
    else $error("gates not off after timer trip");
  a_sync_not_early: assert property ($rose(timer_threshold_in) && gate_enable |=> gate_enable)
    else $error("trip acted before synchronisation");
  a_cool_hold_off: assert property ($fell(gate_enable) |=> !gate_enable [*8])
    else $error("gates back on before cooling");
  a_fold_in_span: assert property (fold_pct_q >= 7'h0A && fold_pct_q <= 7'h64)
    else $error("fold ratio outside span");
  a_startup_flat: assert property ((!power_good_in) [*5] |->
      fold_pct_q inside {7'h0A, 7'h14, 7'h32, 7'h64})
    else $error("startup fold not flat");
  a_high_out_fold: assert property ((power_good_in && out_mv_in >= 11'h708) [*5] |->
      fold_pct_q inside {7'h32, 7'h64})
    else $error("fold wrong at top output");
endmodule
bind ocrfc_ctrl ocrfc_ctrl_chk #(.COOL_BASE_CYC(COOL_BASE_CYC),
  .RETRY_RESET_CYC(RETRY_RESET_CYC)) chk (.*);
`default_nettype wire

// >>> verification/ocrfc_load_model.sv
// Overload and fault-timer comparator model facing the controller.
// Assumes the bench raises overload only while it wants a fault.
`timescale 1ns/1ps
`default_nettype none
module ocrfc_load_model #(
  parameter int CHG = 10
) (
  input  wire logic clk,
  input  wire logic gate_enable,
  input  wire logic overload,
  output wire logic limit_engaged_in,
  output wire logic timer_charging_in,
  output wire logic timer_threshold_in
);
  int n = 0;
  // The timer node discharges as soon as the gates open, so every level drops with them.
  always @(negedge clk) begin
    n <= (overload && gate_enable) ? n + 1 : 0;
  end
  assign limit_engaged_in   = n > 0;
  assign timer_charging_in  = n > 0;
  assign timer_threshold_in = n > CHG;
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the overcurrent retry and foldback controller.
// Assumes short cooling and reset-timer counts set through parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int COOL = 20;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        gate_on_req = 1'b1;
  logic        power_good_in = 1'b0;
  logic [10:0] out_mv_in = 11'h000;
  logic        overload = 1'b0;
  logic [31:0] rnd = 32'h0690;
  logic [7:0]  reg_rdata;
  logic [5:0]  sense_limit_voltage;
  logic [6:0]  fast_pulldown_threshold, fold_pct_q;
  wire         limit_engaged_in, timer_charging_in, timer_threshold_in, gate_enable;
  int          failures = 0;
  int          tests_run = 0;
  initial forever #20 clk = ~clk;
  ocrfc_ctrl #(.COOL_BASE_CYC(COOL), .RETRY_RESET_CYC(200)) dut (.*);
  ocrfc_load_model load (.*);
  // ====================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_fold(input int k);
    logic [7:0] t;
    t = k[3:2] == 0 ? 8'h0A : k[3:2] == 1 ? 8'h14 : k[3:2] == 2 ? 8'h32 : 8'h64;
    if (!k[4] || (k < 32 && !k[0])) return t;
    return (k >= 64 && k[1]) ? 8'h32 : 8'h64;
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr = a;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic reset_dut;
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(2);
  endtask
  task automatic wait_gate(input logic lvl, input int lim, output int n);
    n = 0;
    while (gate_enable !== lvl) begin
      cyc(1);
      n++;
      if (n > lim) begin
        failures++;
        test_done();
      end
    end
  endtask
  // One overload; back selects a retry, m is the expected delay-running bit.
  task automatic fault(input bit back, input int exp, input logic [7:0] m);
    int n;
    wait_gate(1'b1, 40, n);
    wr(8'h04, 8'h02);
    rd(8'h04, 8'h02, 8'h00);
    overload = 1'b1;
    cyc(6);
    rd(8'h03, 8'h02, 8'h02);
    wait_gate(1'b0, 40, n);
    overload = 1'b0;
    cyc(2);
    rd(8'h04, 8'h02, 8'h02);
    rd(8'h03, 8'h02, 8'h00);
    rd(8'hA2, 8'h01, m);
    if (back) begin
      wait_gate(1'b1, exp + 40, n);
      chk({7'h00, n + 3 >= exp && n <= exp + 4}, 8'h01);
      rd(8'hA2, 8'h01, 8'h00);
    end else begin
      cyc(300);
      chk({7'h00, gate_enable}, 8'h00);
    end
  endtask
  // ====================================================================
  // Scenarios
  initial begin
    int n, e, c;
    reset_dut();
    rd(8'h0B, 8'hFF, 8'h00);
    rd(8'h0E, 8'hFF, 8'h00);
    rd(8'h55, 8'hFF, 8'h00);
    rd(8'hAD, 8'hFF, 8'h0F);
    rd(8'h0D, 8'h0F, 8'h0F);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      wr(8'h0D, {rnd[7:4], i[3:0]});
      chk({2'h0, sense_limit_voltage}, 8'(15 + i));
      chk({1'h0, fast_pulldown_threshold}, 8'(30 + 2 * i));
    end
    for (int k = 0; k < 96; k++) begin
      wr(8'h0D, {k[0], k[1], k[3:2], 4'h5});
      power_good_in = k[4];
      out_mv_in = 11'(k / 32 * 900);
      cyc(7);
      chk({1'h0, fold_pct_q}, exp_fold(k));
    end
    power_good_in = 1'b1;
    // Mid points of both ramps, with load-power foldback on.
    for (int s = 0; s < 4; s++) begin
      wr(8'h0D, {2'h1, 2'(s), 4'h5});
      out_mv_in = 11'h1C2;
      cyc(7);
      chk({1'h0, fold_pct_q}, 8'(exp_fold(4 * s) + (8'h64 - exp_fold(4 * s)) / 2));
      out_mv_in = 11'h546;
      cyc(7);
      chk({1'h0, fold_pct_q}, 8'h4B);
    end
    for (int r = 1; r < 4; r++) begin
      reset_dut();
      rnd = lfsr(rnd);
      c = rnd % 3;
      wr(8'h0B, 8'(r));
      wr(8'h0E, 8'(c));
      e = r == 1 ? 1 : r == 2 ? 7 : 9;
      for (int j = 0; j <= e; j++) fault(j < e || r == 3, COOL << c, 8'(j < e || r == 3));
    end
    reset_dut();
    wr(8'h0B, 8'h01);
    fault(1, COOL, 8'h01);
    cyc(250);
    fault(1, COOL, 8'h01);
    power_good_in = 1'b0;
    cyc(300);
    power_good_in = 1'b1;
    cyc(4);
    fault(0, COOL, 8'h00);
    reset_dut();
    fault(0, COOL, 8'h00);
    wr(8'h04, 8'h02);
    rd(8'h04, 8'h02, 8'h00);
    wait_gate(1'b1, 4 * COOL, n);
    chk({7'h00, gate_enable}, 8'h01);
    chk({7'h00, n + 2 >= COOL && n <= COOL + 2}, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
